// *** src/seq_ctl_regs.svh ***
// Register offsets, field positions, masks, the last step index and reset values.
// Assumes byte addresses on a 32-bit Avalon-MM slave.
`ifndef SEQ_CTL_REGS_SVH
`define SEQ_CTL_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_COMMAND        8'h00
`define OFS_STATUS         8'h04
`define OFS_IRQ_MASK       8'h08
`define OFS_IRQ_STATUS     8'h0c
`define OFS_SEQ0_INPUT_SEL 8'h40
`define OFS_SEQ0_STEP_CTL  8'h44
`define OFS_SEQ3_INPUT_SEL 8'ha0
`define OFS_SEQ3_STEP_CTL  8'ha4

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define CMD_START_SEQ0     0
`define CMD_START_SEQ3     1
`define IRQ_SEQ0_BIT       0
`define IRQ_SEQ3_BIT       1
`define IRQ_WIDTH          2
`define INPUT_SEL_MASK     32'h33333333
`define SEQ3_CTL_MASK      32'h0000000f
`define SEQ3_SEL_MASK      32'h00000003
`define SEQ3_LAST_FORCE    32'h00000002
`define LAST_STEP_INDEX    3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_STEP_CTL       32'h00000000
`define RST_INPUT_SEL      32'h00000000
`define RST_IRQ            2'h0

`endif

// *** src/seq_ctl_pkg.sv ***
// Types shared by the sequencer step control block.
// Assumes the offsets and fields of seq_ctl_regs.svh.
package seq_ctl_pkg;

    // ************************************************************
    // Step group, conversion request and sequence state
    // ************************************************************
    typedef struct packed {
        logic sensor;
        logic irq_en;
        logic last;
        logic diff;
    } step_group_type;

    typedef struct packed {
        logic       temp;
        logic       diff;
        logic [2:0] pos_input;
        logic [2:0] neg_input;
    } conv_sel_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ  = 3'b010,
        ST_WAIT = 3'b100
    } seq_state_type;

endpackage : seq_ctl_pkg

// *** src/step_decode.sv ***
// Turns one step group and its input-select field into a conversion
// request. Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module step_decode (
    input  wire seq_ctl_pkg::step_group_type group,
    input  wire logic [1:0]                  input_select,
    output seq_ctl_pkg::conv_sel_type        conv_sel
);

    always_comb begin
        conv_sel.temp      = group.sensor;
        conv_sel.diff      = group.diff & ~group.sensor;
        conv_sel.pos_input = {1'b0, input_select};
        conv_sel.neg_input = 3'h0;
        if (conv_sel.diff) begin
            conv_sel.pos_input = {input_select, 1'b0};
            conv_sel.neg_input = {input_select, 1'b1};
        end
    end

endmodule : step_decode

// *** src/irq_block.sv ***
// Sticky interrupt status with write-one-to-clear, mask and one
// level interrupt output. Assumes set pulses on the same clock.
`timescale 1ns/100ps
`include "seq_ctl_regs.svh"
module irq_block (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic [`IRQ_WIDTH-1:0] set_pulse,
    input  wire logic                   clear_write,
    input  wire logic                   mask_write,
    input  wire logic [`IRQ_WIDTH-1:0] write_data,
    output logic      [`IRQ_WIDTH-1:0] status_reg,
    output logic      [`IRQ_WIDTH-1:0] mask_reg,
    output logic                        irq_reg
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // ************************************************************
    // Status, mask and output
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_reg <= `RST_IRQ;
        end else begin
            status_reg <= (status_reg & ~({`IRQ_WIDTH{clear_write}}
                          & write_data)) | set_pulse;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mask_reg <= `RST_IRQ;
        end else if (mask_write) begin
            mask_reg <= write_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
        end
    end

    a_irq_masked_off: assert property (
        (mask_reg == 2'h0) ##1 (mask_reg == 2'h0) |-> !irq_reg)
        else $error("Interrupt raised while all masks are clear.");

    a_irq_seq0_fwd: assert property (
        status_reg[`IRQ_SEQ0_BIT] && mask_reg[`IRQ_SEQ0_BIT] |=> irq_reg)
        else $error("Unmasked raw flag did not raise interrupt.");

    a_set_wins_clear: assert property (
        set_pulse[`IRQ_SEQ0_BIT] |=> status_reg[`IRQ_SEQ0_BIT])
        else $error("Raw flag set was lost.");

endmodule : irq_block

// *** src/adc_seq0_step_control.sv ***
// Step control of sample sequencer 0 (and the one-step sequencer 3)
// with an Avalon-MM register slave and the conversion request port.
// Assumes the conversion core runs on sys_clk and pulses conv_done.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "seq_ctl_regs.svh"
module adc_seq0_step_control (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        conv_done,
    output logic             conv_req,
    output seq_ctl_pkg::conv_sel_type conv_sel,
    output logic             irq
);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [31:0]                   seq0_step_control_reg;
    logic [31:0]                   seq0_input_sel_reg;
    logic [3:0]                    seq3_step_control_reg;
    logic [1:0]                    seq3_input_sel_reg;
    logic [31:0]                   write_value;
    logic [31:0]                   read_value;
    logic                          write_now;
    logic                          start_seq0;
    logic                          start_seq3;
    logic                          seq3_active_reg;
    logic [2:0]                    step_reg;
    seq_ctl_pkg::seq_state_type    state_reg;
    seq_ctl_pkg::step_group_type   cur_group;
    logic [1:0]                    cur_select;
    seq_ctl_pkg::conv_sel_type     sel_next;
    logic                          step_finish;
    logic                          seq_end;
    logic [`IRQ_WIDTH-1:0]         irq_set;
    logic [`IRQ_WIDTH-1:0]         irq_status;
    logic [`IRQ_WIDTH-1:0]         irq_mask;
    logic [31:0]                   seq3_ctl_view;

    // ************************************************************
    // Avalon-MM handshake
    // ************************************************************
    // Every access waits one cycle; the second edge completes it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    assign write_now = avs_write && !avs_waitrequest;

    // Byte lanes merge into the value being written.
    always_comb begin
        write_value = read_value;
        for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
                write_value[b*8 +: 8] = avs_writedata[b*8 +: 8];
            end
        end
    end

    assign seq3_ctl_view = {28'h0000000, seq3_step_control_reg}
                         | `SEQ3_LAST_FORCE;

    always_comb begin
        read_value = 32'h00000000;
        unique case (avs_address)
            `OFS_COMMAND: begin
                read_value = 32'h00000000;
            end
            `OFS_STATUS: begin
                read_value = {27'h0000000, seq3_active_reg, step_reg,
                              state_reg != seq_ctl_pkg::ST_IDLE};
            end
            `OFS_IRQ_MASK: begin
                read_value = {30'h00000000, irq_mask};
            end
            `OFS_IRQ_STATUS: begin
                read_value = {30'h00000000, irq_status};
            end
            `OFS_SEQ0_INPUT_SEL: begin
                read_value = seq0_input_sel_reg;
            end
            `OFS_SEQ0_STEP_CTL: begin
                read_value = seq0_step_control_reg;
            end
            `OFS_SEQ3_INPUT_SEL: begin
                read_value = {30'h00000000, seq3_input_sel_reg};
            end
            `OFS_SEQ3_STEP_CTL: begin
                read_value = seq3_ctl_view;
            end
            default: begin
                read_value = 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= read_value;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq0_step_control_reg <= `RST_STEP_CTL;
        end else if (write_now && avs_address == `OFS_SEQ0_STEP_CTL) begin
            seq0_step_control_reg <= write_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq0_input_sel_reg <= `RST_INPUT_SEL;
        end else if (write_now && avs_address == `OFS_SEQ0_INPUT_SEL) begin
            seq0_input_sel_reg <= write_value & `INPUT_SEL_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq3_step_control_reg <= 4'h0;
        end else if (write_now && avs_address == `OFS_SEQ3_STEP_CTL) begin
            seq3_step_control_reg <= write_value[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq3_input_sel_reg <= 2'h0;
        end else if (write_now && avs_address == `OFS_SEQ3_INPUT_SEL) begin
            seq3_input_sel_reg <= write_value[1:0];
        end
    end

    assign start_seq0 = write_now && avs_address == `OFS_COMMAND
                     && avs_writedata[`CMD_START_SEQ0];
    assign start_seq3 = write_now && avs_address == `OFS_COMMAND
                     && avs_writedata[`CMD_START_SEQ3];

    // ************************************************************
    // Current step group
    // ************************************************************
    always_comb begin
        if (seq3_active_reg) begin
            cur_group  = seq3_ctl_view[3:0];
            cur_select = seq3_input_sel_reg;
        end else begin
            cur_group  = seq0_step_control_reg[step_reg*4 +: 4];
            cur_select = seq0_input_sel_reg[step_reg*4 +: 2];
        end
    end

    step_decode u_step_decode (
        .group        (cur_group),
        .input_select (cur_select),
        .conv_sel     (sel_next)
    );

    assign step_finish = state_reg == seq_ctl_pkg::ST_WAIT && conv_done;
    assign seq_end     = cur_group.last || seq3_active_reg
                      || step_reg == `LAST_STEP_INDEX;

    // ************************************************************
    // Sequence state machine
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= seq_ctl_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                seq_ctl_pkg::ST_IDLE: begin
                    if (start_seq0 || start_seq3) begin
                        state_reg <= seq_ctl_pkg::ST_REQ;
                    end
                end
                seq_ctl_pkg::ST_REQ: begin
                    state_reg <= seq_ctl_pkg::ST_WAIT;
                end
                seq_ctl_pkg::ST_WAIT: begin
                    if (conv_done && seq_end) begin
                        state_reg <= seq_ctl_pkg::ST_IDLE;
                    end else if (conv_done) begin
                        state_reg <= seq_ctl_pkg::ST_REQ;
                    end
                end
                default: begin
                    state_reg <= seq_ctl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            step_reg <= 3'h0;
        end else if (state_reg == seq_ctl_pkg::ST_IDLE) begin
            step_reg <= 3'h0;
        end else if (step_finish && !seq_end) begin
            step_reg <= step_reg + 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seq3_active_reg <= 1'b0;
        end else if (state_reg == seq_ctl_pkg::ST_IDLE) begin
            seq3_active_reg <= start_seq3 && !start_seq0;
        end
    end

    // ************************************************************
    // Conversion request port
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_req <= 1'b0;
        end else if (state_reg == seq_ctl_pkg::ST_REQ) begin
            conv_req <= 1'b1;
        end else if (conv_done) begin
            conv_req <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_sel <= '0;
        end else if (state_reg == seq_ctl_pkg::ST_REQ) begin
            conv_sel <= sel_next;
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irq_set[`IRQ_SEQ0_BIT] = step_finish && !seq3_active_reg
                                 && cur_group.irq_en;
    assign irq_set[`IRQ_SEQ3_BIT] = step_finish && seq3_active_reg
                                 && cur_group.irq_en;

    irq_block u_irq_block (
        .sys_clk     (sys_clk),
        .srst        (srst),
        .set_pulse   (irq_set),
        .clear_write (write_now && avs_address == `OFS_IRQ_STATUS
                      && avs_byteenable[0]),
        .mask_write  (write_now && avs_address == `OFS_IRQ_MASK),
        .write_data  (write_value[`IRQ_WIDTH-1:0]),
        .status_reg  (irq_status),
        .mask_reg    (irq_mask),
        .irq_reg     (irq)
    );

    // ************************************************************
    // Assertions
    // ************************************************************
    a_temp_source: assert property (
        state_reg == seq_ctl_pkg::ST_WAIT |-> conv_sel.temp == cur_group.sensor)
        else $error("Source does not follow the sensor bit.");

    a_pin_select: assert property (
        state_reg == seq_ctl_pkg::ST_WAIT && !conv_sel.temp && !conv_sel.diff
        |-> conv_sel.pos_input == {1'b0, cur_select})
        else $error("Pin does not follow the input select.");

    a_diff_pair: assert property (
        state_reg == seq_ctl_pkg::ST_WAIT && conv_sel.diff
        |-> conv_sel.pos_input == {cur_select, 1'b0}
            && conv_sel.neg_input == {cur_select, 1'b1})
        else $error("Differential pair inputs wrong.");

    a_temp_no_diff: assert property (
        conv_sel.temp |-> !conv_sel.diff)
        else $error("Differential set on temperature sensor.");

    a_raw_flag_set: assert property (
        step_finish && !seq3_active_reg && cur_group.irq_en
        |=> irq_status[`IRQ_SEQ0_BIT])
        else $error("Raw flag not raised after enabled step.");

    a_flag_untouched: assert property (
        !irq_status[`IRQ_SEQ0_BIT] && !irq_set[`IRQ_SEQ0_BIT]
        |=> !irq_status[`IRQ_SEQ0_BIT])
        else $error("Raw flag rose without an enabled step.");

    a_last_step_ends: assert property (
        step_finish && cur_group.last
        |=> state_reg == seq_ctl_pkg::ST_IDLE ##1 !conv_req)
        else $error("Sequence ran past the end mark.");

    a_step_order: assert property (
        step_finish && !seq_end
        |=> step_reg == $past(step_reg) + 3'h1
            && state_reg == seq_ctl_pkg::ST_REQ ##1 conv_req)
        else $error("Steps did not advance in order.");

    a_seq3_single: assert property (
        step_finish && seq3_active_reg |=> state_reg == seq_ctl_pkg::ST_IDLE)
        else $error("One-step sequencer did not end.");

    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("Bus access not answered in one cycle.");

endmodule : adc_seq0_step_control

// *** tb/conv_core_model.sv ***
// Behavioural conversion core that answers each request with one pulse.
// Assumes conv_req holds until the edge after conv_done is seen.
`timescale 1ns/100ps
module conv_core_model (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       conv_req,
    input  wire logic [3:0] hold_cycles,
    output logic            conv_done
);
    logic [3:0] count_reg;
    logic       answered_reg;

    // ************************************************************
    // Answer
    // ************************************************************
    // One pulse per request after hold_cycles cycles, never while idle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_done    <= 1'b0;
            count_reg    <= 4'h0;
            answered_reg <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (!conv_req) begin
                answered_reg <= 1'b0;
                count_reg    <= 4'h0;
            end else if (!answered_reg) begin
                if (count_reg == hold_cycles) begin
                    conv_done    <= 1'b1;
                    answered_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 4'h1;
                end
            end
        end
    end
endmodule : conv_core_model

// *** tb/adc_seq0_step_control_tb_top.sv ***
// Self-checking bench of the step control block and its register slave.
// Assumes conv_core_model answers requests on the far side.
`timescale 1ns/100ps
`include "seq_ctl_regs.svh"
`define CHK(what, exp, got) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module adc_seq0_step_control_tb_top;
    logic                      sys_clk;
    logic                      srst;
    logic [7:0]                avs_address;
    logic                      avs_read;
    logic                      avs_write;
    logic [31:0]               avs_writedata;
    logic [3:0]                avs_byteenable;
    logic [31:0]               avs_readdata;
    logic                      avs_waitrequest;
    logic                      conv_done;
    logic                      conv_req;
    seq_ctl_pkg::conv_sel_type conv_sel;
    logic                      irq;
    logic [3:0]                hold_cycles;
    int                        err_count;
    int                        n_checks;
    int                        cycle_count;
    logic                      req_seen;
    logic [31:0]               rd;
    logic [31:0]               v;
    logic [1:0]                mask_m;
    logic [1:0]                flag_m;
    seq_ctl_pkg::conv_sel_type seen_q[$];
    seq_ctl_pkg::conv_sel_type exp_q[$];

    adc_seq0_step_control adc_seq0_step_control_i (
        .sys_clk        (sys_clk),
        .srst           (srst),
        .avs_address    (avs_address),
        .avs_read       (avs_read),
        .avs_write      (avs_write),
        .avs_writedata  (avs_writedata),
        .avs_byteenable (avs_byteenable),
        .avs_readdata   (avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .conv_done      (conv_done),
        .conv_req       (conv_req),
        .conv_sel       (conv_sel),
        .irq            (irq)
    );

    conv_core_model conv_core_model_i (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .conv_req   (conv_req),
        .hold_cycles(hold_cycles),
        .conv_done  (conv_done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Monitor and timeout
    // ************************************************************
    always @(posedge sys_clk) begin
        cycle_count <= cycle_count + 1;
        req_seen    <= conv_req;
        if (conv_req === 1'b1 && req_seen !== 1'b1) begin
            seen_q.push_back(conv_sel);
        end
        if (cycle_count == 60000) begin
            err_count++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be);
        @(posedge sys_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_rd

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                          input string what);
        bus_rd(a, rd);
        `CHK(what, e, rd)
    endtask : chk_rd

    // Builds the expected requests of one sequence and its raw flag.
    function automatic void expect_seq(input logic [31:0] c,
                                       input logic [31:0] s,
                                       input int last, input int b);
        seq_ctl_pkg::conv_sel_type e;
        logic [3:0]                g;
        logic [1:0]                i;
        exp_q.delete();
        for (int n = 0; n <= last; n++) begin
            g = c[4*n+:4];
            i = s[4*n+:2];
            e.temp = g[3];
            e.diff = g[0] & ~g[3];
            e.pos_input = e.diff ? {i, 1'b0} : {1'b0, i};
            e.neg_input = e.diff ? {i, 1'b1} : 3'h0;
            exp_q.push_back(e);
            if (g[2]) flag_m[b] = 1'b1;
            if (g[1]) break;
        end
    endfunction : expect_seq

    task automatic run_seq(input logic s3, input logic [31:0] c,
                           input logic [31:0] s);
        seq_ctl_pkg::conv_sel_type g;
        seq_ctl_pkg::conv_sel_type e;
        bus_wr(s3 ? `OFS_SEQ3_STEP_CTL : `OFS_SEQ0_STEP_CTL, c, 4'hf);
        bus_wr(s3 ? `OFS_SEQ3_INPUT_SEL : `OFS_SEQ0_INPUT_SEL, s, 4'hf);
        flag_m = 2'h0;
        if (s3) expect_seq((c & `SEQ3_CTL_MASK) | `SEQ3_LAST_FORCE, s, 0, 1);
        else expect_seq(c, s, 7, 0);
        seen_q.delete();
        hold_cycles <= 4'($urandom_range(5));
        bus_wr(`OFS_COMMAND, s3 ? 32'h2 : 32'h1, 4'hf);
        do bus_rd(`OFS_STATUS, rd); while (rd[0] !== 1'b0 || rd[4] !== 1'b0);
        `CHK("step count", exp_q.size(), seen_q.size())
        while (exp_q.size() > 0 && seen_q.size() > 0) begin
            e = exp_q.pop_front();
            g = seen_q.pop_front();
            if (e.temp) g.pos_input = e.pos_input;
            `CHK("conv_sel", e, g)
        end
        chk_rd(`OFS_IRQ_STATUS, {30'h0, flag_m}, "raw flag");
        `CHK("irq", |(flag_m & mask_m), irq)
        bus_wr(`OFS_IRQ_STATUS, 32'h3, 4'he);
        chk_rd(`OFS_IRQ_STATUS, {30'h0, flag_m}, "lane clear");
        bus_wr(`OFS_IRQ_STATUS, 32'h3, 4'hf);
        chk_rd(`OFS_IRQ_STATUS, 32'h0, "flag clear");
        `CHK("irq clear", 1'b0, irq)
    endtask : run_seq

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        srst           = 1'b1;
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
        hold_cycles    = 4'h0;
        err_count      = 0;
        n_checks       = 0;
        cycle_count    = 0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        rd = $urandom(76397);
        chk_rd(`OFS_SEQ0_STEP_CTL, `RST_STEP_CTL, "ctl reset");
        v = $urandom();
        bus_wr(`OFS_SEQ0_STEP_CTL, v, 4'hf);
        chk_rd(`OFS_SEQ0_STEP_CTL, v, "ctl rw");
        bus_wr(`OFS_SEQ0_STEP_CTL, ~v, 4'h2);
        chk_rd(`OFS_SEQ0_STEP_CTL, {v[31:16], ~v[15:8], v[7:0]}, "lanes");
        bus_wr(`OFS_SEQ0_INPUT_SEL, v, 4'hf);
        chk_rd(`OFS_SEQ0_INPUT_SEL, v & `INPUT_SEL_MASK, "sel rw");
        bus_wr(`OFS_SEQ3_STEP_CTL, 32'h0, 4'hf);
        chk_rd(`OFS_SEQ3_STEP_CTL, `SEQ3_LAST_FORCE, "seq3 mark");
        bus_wr(8'h10, v, 4'hf);
        chk_rd(8'h10, 32'h0, "unmapped");
        chk_rd(`OFS_COMMAND, 32'h0, "command");
        for (int t = 0; t < 24; t++) begin
            mask_m = 2'($urandom());
            bus_wr(`OFS_IRQ_MASK, {30'h0, mask_m}, 4'hf);
            chk_rd(`OFS_IRQ_MASK, {30'h0, mask_m}, "mask");
            v = $urandom();
            if (t == 0) v = 32'h20000000;
            else if (t == 1) v = v | 32'h2;
            else if (t == 2) v = (v & 32'hdddddddd) | 32'h20000000;
            else v[4 * ($urandom() % 8) + 1] = 1'b1;
            run_seq(t % 4 == 3, v, $urandom());
        end
        results();
    end
endmodule : adc_seq0_step_control_tb_top
